// >>> acq_sync_defines.vh
// constants for the acquisition sync and trigger control block
//
// Behaviour
// - four video input channels share one digitizer and only the selected channel is passed on.
// - in slave mode line timing, and frame timing except with composite sync, come from the attached video source.
// - slave mode uses one chosen sync scheme: embedded, separate horizontal/vertical, or composite.
// - in master mode the block generates horizontal and vertical sync and drives it to the source.
// - an external trigger input aligns the start of acquisition with the outside event.
// - two exposure timers, retriggerable by software and by hardware, drive the exposure outputs.
// - channel select, arm, trigger mode, exposure time, gain and palette may change at run time; the rest is set up once.
`ifndef ACQ_SYNC_DEFINES_VH
`define ACQ_SYNC_DEFINES_VH

// register byte offsets
`define REG_CTRL      8'h00
`define REG_CONFIG    8'h04
`define REG_HTIME     8'h08
`define REG_VTIME     8'h0C
`define REG_EXP0      8'h10
`define REG_EXP1      8'h14
`define REG_EXP_KICK  8'h18
`define REG_STATUS    8'h1C

// control register fields
`define CTRL_CHAN_LO   0
`define CTRL_CHAN_HI   1
`define CTRL_TMODE_LO  2
`define CTRL_TMODE_HI  3
`define CTRL_GAIN_LO   4
`define CTRL_GAIN_HI   6
`define CTRL_PAL_LO    8
`define CTRL_PAL_HI    11
`define CTRL_ARM       12

// configuration register fields
`define CFG_MASTER     0
`define CFG_SCHEME_LO  1
`define CFG_SCHEME_HI  2
`define CFG_LOCK       3

// sync schemes
`define SCHEME_EMBED   2'h0
`define SCHEME_SEP     2'h1
`define SCHEME_COMP    2'h2

// trigger modes
`define TMODE_OFF      2'h0
`define TMODE_RISE     2'h1
`define TMODE_FALL     2'h2

// reset values and master sync pulse widths
`define CTRL_RESET     32'h00000000
`define CONFIG_RESET   32'h00000000
`define HTIME_RESET    32'h0000031F
`define VTIME_RESET    32'h0000020C
`define EXP_RESET      32'h00000100
`define HSYNC_WIDTH    32'h0000005F
`define VSYNC_WIDTH    32'h00000002

// ahb transfer type
`define HTRANS_NONSEQ  2'h2

`endif

// >>> exposure_timer.v
// one retriggerable exposure timer
`timescale 1ns/1ps
`default_nettype none

module exposure_timer #(
    parameter WIDTH = 32
) (
    input  wire             clk_in,
    input  wire             rstn_in,
    input  wire             kick_in,
    input  wire [WIDTH-1:0] duration_in,
    output reg              active_out,
    output reg  [WIDTH-1:0] remain_out
);

    // a kick with a nonzero duration reloads the full duration, running or not; a zero duration ignores it
    always @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            active_out <= 1'b0;
            remain_out <= {WIDTH{1'b0}};
        end
        else if (kick_in && (duration_in != {WIDTH{1'b0}}))
        begin
            active_out <= 1'b1;
            remain_out <= duration_in - {{(WIDTH-1){1'b0}}, 1'b1};
        end
        else if (active_out)
        begin
            if (remain_out == {WIDTH{1'b0}})
                active_out <= 1'b0;
            else
                remain_out <= remain_out - {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

endmodule // exposure_timer

`default_nettype wire

// >>> acq_sync_ctrl.v
// acquisition channel select, sync master/slave, trigger and exposure control with AHB-Lite registers
`timescale 1ns/1ps
`default_nettype none
`include "acq_sync_defines.vh"

module acq_sync_ctrl #(
    parameter CNT_W = 32
) (
    input  wire        clk_in,
    input  wire        rstn_in,
    // ahb-lite slave
    input  wire        hsel_in,
    input  wire [7:0]  haddr_in,
    input  wire [1:0]  htrans_in,
    input  wire        hwrite_in,
    input  wire [2:0]  hsize_in,
    input  wire        hready_in,
    input  wire [31:0] hwdata_in,
    output wire [31:0] hrdata_out,
    output wire        hreadyout_out,
    output wire        hresp_out,
    // video side
    input  wire [3:0]  video_in,
    input  wire        emb_hsync_in,
    input  wire        emb_vsync_in,
    input  wire        hsync_in,
    input  wire        vsync_in,
    input  wire        csync_in,
    input  wire        trigger_in,
    output reg         video_out,
    output reg         hsync_out,
    output reg         hsync_oe_out,
    output reg         vsync_out,
    output reg         vsync_oe_out,
    output reg         line_start_out,
    output reg         frame_start_out,
    output reg         acq_start_out,
    output wire [1:0]  exposure_out,
    output reg  [2:0]  gain_out,
    output reg  [3:0]  palette_out
);

    reg  [31:0] ctrl;
    reg  [31:0] config_reg;
    reg  [31:0] htime;
    reg  [31:0] vtime;
    reg  [31:0] exp0;
    reg  [31:0] exp1;
    reg  [1:0]  sw_kick;
    reg         wr_pend;
    reg  [7:0]  wr_addr;
    reg  [31:0] rdata;
    reg  [CNT_W-1:0] hcnt;
    reg  [CNT_W-1:0] vcnt;
    reg         h_prev;
    reg         v_prev;
    reg         trig_prev;
    reg         trig_seen;
    wire        sel_h;
    wire        sel_v;
    wire        h_edge;
    wire        v_edge;
    wire        trig_hit;
    wire        master;
    wire [1:0]  tmode;
    wire [1:0]  kick;
    wire        addr_ok;

    assign master = config_reg[`CFG_MASTER];
    assign tmode  = ctrl[`CTRL_TMODE_HI:`CTRL_TMODE_LO];

    // bus always answers at once with OKAY
    assign hreadyout_out = 1'b1;
    assign hresp_out     = 1'b0;
    assign hrdata_out    = rdata;
    assign addr_ok       = hsel_in && hready_in && (htrans_in == `HTRANS_NONSEQ);

    // register address decode used by the write path; reads decode haddr_in in their own case
    function is_mapped;
        input [7:0] a;
        begin
            is_mapped = (a <= `REG_STATUS) && (a[1:0] == 2'h0);
        end
    endfunction

    // write capture in address phase, commit in data phase
    always @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end
        else
        begin
            wr_pend <= addr_ok && hwrite_in;
            wr_addr <= haddr_in;
        end
    end

    // register file; config and timing are the setup-time camera profile, ctrl, exp0 and exp1 are the run-time set
    always @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            ctrl       <= `CTRL_RESET;
            config_reg <= `CONFIG_RESET;
            htime      <= `HTIME_RESET;
            vtime      <= `VTIME_RESET;
            exp0       <= `EXP_RESET;
            exp1       <= `EXP_RESET;
            sw_kick    <= 2'h0;
        end
        else
        begin
            sw_kick <= 2'h0;
            if (wr_pend && is_mapped(wr_addr))
            begin
                case (wr_addr)
                    `REG_CTRL:     ctrl <= hwdata_in;
                    // profile is frozen once locked; only a reset reopens it
                    `REG_CONFIG:   if (!config_reg[`CFG_LOCK]) config_reg <= hwdata_in;
                    `REG_HTIME:    if (!config_reg[`CFG_LOCK]) htime <= hwdata_in;
                    `REG_VTIME:    if (!config_reg[`CFG_LOCK]) vtime <= hwdata_in;
                    `REG_EXP0:     exp0 <= hwdata_in;
                    `REG_EXP1:     exp1 <= hwdata_in;
                    `REG_EXP_KICK: sw_kick <= hwdata_in[1:0];
                    default:       ctrl <= ctrl;
                endcase
            end
        end
    end

    // read data registered in the address phase
    always @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            rdata <= 32'h00000000;
        else if (addr_ok && !hwrite_in)
        begin
            case (haddr_in)
                `REG_CTRL:     rdata <= ctrl;
                `REG_CONFIG:   rdata <= config_reg;
                `REG_HTIME:    rdata <= htime;
                `REG_VTIME:    rdata <= vtime;
                `REG_EXP0:     rdata <= exp0;
                `REG_EXP1:     rdata <= exp1;
                `REG_STATUS:   rdata <= {25'h0000000, trig_seen, exposure_out, vsync_out, hsync_out,
                                         master, 1'b0};
                default:       rdata <= 32'h00000000;
            endcase
        end
    end

    // channel mux: one digitizer, one selected input
    always @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            video_out   <= 1'b0;
            gain_out    <= 3'h0;
            palette_out <= 4'h0;
        end
        else
        begin
            video_out   <= video_in[ctrl[`CTRL_CHAN_HI:`CTRL_CHAN_LO]];
            gain_out    <= ctrl[`CTRL_GAIN_HI:`CTRL_GAIN_LO];
            palette_out <= ctrl[`CTRL_PAL_HI:`CTRL_PAL_LO];
        end
    end

    // slave sync source by scheme; composite gives horizontal only, vertical is held low
    assign sel_h = (config_reg[`CFG_SCHEME_HI:`CFG_SCHEME_LO] == `SCHEME_EMBED) ? emb_hsync_in :
                   (config_reg[`CFG_SCHEME_HI:`CFG_SCHEME_LO] == `SCHEME_SEP)   ? hsync_in : csync_in;
    assign sel_v = (config_reg[`CFG_SCHEME_HI:`CFG_SCHEME_LO] == `SCHEME_EMBED) ? emb_vsync_in :
                   (config_reg[`CFG_SCHEME_HI:`CFG_SCHEME_LO] == `SCHEME_SEP)   ? vsync_in : 1'b0;
    assign h_edge = sel_h && !h_prev;
    assign v_edge = sel_v && !v_prev;

    // sync: master counts its own raster, slave follows the source edges
    always @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            hcnt            <= {CNT_W{1'b0}};
            vcnt            <= {CNT_W{1'b0}};
            h_prev          <= 1'b0;
            v_prev          <= 1'b0;
            hsync_out       <= 1'b0;
            vsync_out       <= 1'b0;
            hsync_oe_out    <= 1'b0;
            vsync_oe_out    <= 1'b0;
            line_start_out  <= 1'b0;
            frame_start_out <= 1'b0;
        end
        else
        begin
            h_prev       <= sel_h;
            v_prev       <= sel_v;
            hsync_oe_out <= master;
            vsync_oe_out <= master;
            if (master)
            begin
                // the source must lock to these, nothing here checks that it did
                hcnt <= (hcnt >= htime[CNT_W-1:0]) ? {CNT_W{1'b0}} : hcnt + 1'b1;
                if (hcnt >= htime[CNT_W-1:0])
                    vcnt <= (vcnt >= vtime[CNT_W-1:0]) ? {CNT_W{1'b0}} : vcnt + 1'b1;
                hsync_out       <= (hcnt < `HSYNC_WIDTH);
                vsync_out       <= (vcnt < `VSYNC_WIDTH);
                line_start_out  <= (hcnt == {CNT_W{1'b0}});
                frame_start_out <= (hcnt == {CNT_W{1'b0}}) && (vcnt == {CNT_W{1'b0}});
            end
            else
            begin
                hcnt            <= {CNT_W{1'b0}};
                vcnt            <= {CNT_W{1'b0}};
                hsync_out       <= sel_h;
                vsync_out       <= sel_v;
                line_start_out  <= h_edge;
                frame_start_out <= v_edge;
            end
        end
    end

    // trigger edge by mode; pulses shorter than one clock may be missed
    assign trig_hit = ((tmode == `TMODE_RISE) && trigger_in && !trig_prev) ||
                      ((tmode == `TMODE_FALL) && !trigger_in && trig_prev);

    // acquisition starts at the first frame after the trigger, armed or not; with trigger off, arm starts every frame
    always @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            trig_prev     <= 1'b0;
            trig_seen     <= 1'b0;
            acq_start_out <= 1'b0;
        end
        else
        begin
            trig_prev     <= trigger_in;
            acq_start_out <= 1'b0;
            if (tmode == `TMODE_OFF)
            begin
                trig_seen     <= 1'b0;
                acq_start_out <= ctrl[`CTRL_ARM] && frame_start_out;
            end
            else if (trig_hit)
                trig_seen <= 1'b1;
            else if (trig_seen && frame_start_out)
            begin
                trig_seen     <= 1'b0;
                acq_start_out <= 1'b1;
            end
        end
    end

    assign kick = sw_kick | {trig_hit, trig_hit};

    exposure_timer #(
        .WIDTH      (CNT_W)
    ) u_exp0 (
        .clk_in     (clk_in),
        .rstn_in    (rstn_in),
        .kick_in    (kick[0]),
        .duration_in(exp0[CNT_W-1:0]),
        .active_out (exposure_out[0]),
        .remain_out ()  // countdown stays private to the timer
    );

    exposure_timer #(
        .WIDTH      (CNT_W)
    ) u_exp1 (
        .clk_in     (clk_in),
        .rstn_in    (rstn_in),
        .kick_in    (kick[1]),
        .duration_in(exp1[CNT_W-1:0]),
        .active_out (exposure_out[1]),
        .remain_out ()
    );

endmodule // acq_sync_ctrl

`default_nettype wire

// >>> acq_sync_monitor.sv
// port-level assertion checker for the acquisition sync and trigger block
`timescale 1ns/1ps
`default_nettype none
module acq_sync_monitor (
    input wire logic       clk_in,
    input wire logic       rstn_in,
    input wire logic       hsel_in,
    input wire logic       hwrite_in,
    input wire logic [3:0] video_in,
    input wire logic       emb_hsync_in,
    input wire logic       emb_vsync_in,
    input wire logic       hsync_in,
    input wire logic       vsync_in,
    input wire logic       csync_in,
    input wire logic       video_out,
    input wire logic       hsync_out,
    input wire logic       hsync_oe_out,
    input wire logic       vsync_out,
    input wire logic       vsync_oe_out,
    input wire logic       frame_start_out,
    input wire logic       acq_start_out,
    input wire logic [1:0] exposure_out,
    input wire logic [2:0] gain_out,
    input wire logic [3:0] palette_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rstn_in);
    // bench durations are three or more, so each pulse spans at least the two cycles that held_two checks
    sequence held_two(s);
        s ##1 s;
    endsequence
    AST_CHAN: assert property (video_out |-> $past(video_in) != 4'h0) else $error("video without input");
    AST_HSLAVE: assert property (!hsync_oe_out && $rose(hsync_out) |->
        $past(hsync_in | emb_hsync_in | csync_in)) else $error("slave hsync without source");
    AST_VSLAVE: assert property (!vsync_oe_out && $rose(vsync_out) |->
        $past(vsync_in | emb_vsync_in)) else $error("slave vsync without source");
    // drive enables move together, and only after a register write three edges back
    AST_OE: assert property ($changed(hsync_oe_out) |->
        $changed(vsync_oe_out) && $past(hsel_in && hwrite_in, 3)) else $error("sync enables moved apart");
    AST_HMASTER: assert property (hsync_oe_out && $rose(hsync_out) |=> hsync_out [*8])
        else $error("master hsync too short");
    AST_ACQ: assert property (acq_start_out |-> $past(frame_start_out)) else $error("acq not after frame");
    AST_EXP0: assert property ($rose(exposure_out[0]) |-> held_two(exposure_out[0]))
        else $error("exp0 short");
    AST_EXP1: assert property ($rose(exposure_out[1]) |-> held_two(exposure_out[1]))
        else $error("exp1 short");
    AST_RUNTIME: assert property (!$stable({gain_out, palette_out}) |-> $past(hsel_in && hwrite_in, 3))
        else $error("gain changed without write");
endmodule // acq_sync_monitor
`default_nettype wire

// >>> camera_model.sv
// camera and trigger source model facing the acquisition block
`timescale 1ns/1ps
`default_nettype none
module camera_model #(
    parameter LINE = 40
) (
    input  wire logic       clk_in,
    input  wire logic       hs_drive_in,
    input  wire logic       vs_drive_in,
    input  wire logic       drive_on_in,
    input  wire logic       fire_in,
    output var  logic [3:0] video_out,
    output var  logic       hsync_out,
    output var  logic       vsync_out,
    output var  logic       csync_out,
    output var  logic       emb_hsync_out,
    output var  logic       emb_vsync_out,
    output var  logic       trigger_out
);
    int pos = 0;
    int row = 0;
    int hold = 0;
    initial {video_out, hsync_out, vsync_out, csync_out, emb_hsync_out, emb_vsync_out, trigger_out} = '0;
    // own raster; sync phases differ per scheme so a wrong pick shows
    always @(posedge clk_in)
    begin
        pos <= (pos == LINE - 1) ? 0 : pos + 1;
        if (pos == LINE - 1)
            row <= (row == 5) ? 0 : row + 1;
        video_out <= 4'($urandom);
        hsync_out <= pos < 4;
        csync_out <= pos < 6;
        vsync_out <= row == 0;
        emb_hsync_out <= drive_on_in ? hs_drive_in : (pos >= 2 && pos < 8);
        emb_vsync_out <= drive_on_in ? vs_drive_in : row == 1;
        hold <= fire_in ? 3 : (hold > 0 ? hold - 1 : 0);
        trigger_out <= fire_in || hold > 1;
    end
endmodule // camera_model
`default_nettype wire

// >>> test_acquisition_sync_trigger_control.sv
// self-checking bench for the acquisition sync and trigger block
`timescale 1ns/1ps
`default_nettype none
`include "acq_sync_defines.vh"
module test_acquisition_sync_trigger_control;
    logic        clk_in = 0, rstn_in = 0, hsel_in = 0, hwrite_in = 0, fire = 0;
    logic [7:0]  haddr_in = 8'h00;
    logic [1:0]  htrans_in = 2'h0;
    logic [31:0] hwdata_in = 32'h00000000, hrdata_out, d;
    logic        hreadyout_out, hresp_out, video_out, hsync_out, hsync_oe_out, vsync_out, vsync_oe_out;
    logic        line_start_out, frame_start_out, acq_start_out, hp, vp;
    logic        emb_hsync_in, emb_vsync_in, hsync_in, vsync_in, csync_in, trigger_in;
    logic [3:0]  video_in, palette_out;
    logic [2:0]  gain_out;
    logic [1:0]  exposure_out;
    logic [31:0] regs [8] = '{`CTRL_RESET, `CONFIG_RESET, `HTIME_RESET, `VTIME_RESET, `EXP_RESET, `EXP_RESET, 0, 0};
    int          err_total = 0, n_checks = 0, cyc = 0, h0 = 0, h1 = 0, acqs = 0, lns = 0, b0, b1, a0, d0, d1;
    always #2.5 clk_in = ~clk_in;
    acq_sync_ctrl acq_sync_ctrl_inst (.clk_in, .rstn_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in,
        .hsize_in(3'h2), .hready_in(hreadyout_out), .hwdata_in, .hrdata_out, .hreadyout_out, .hresp_out,
        .video_in, .emb_hsync_in, .emb_vsync_in, .hsync_in, .vsync_in, .csync_in, .trigger_in, .video_out,
        .hsync_out, .hsync_oe_out, .vsync_out, .vsync_oe_out, .line_start_out, .frame_start_out,
        .acq_start_out, .exposure_out, .gain_out, .palette_out);
    camera_model camera_model_inst (.clk_in, .hs_drive_in(hsync_out), .vs_drive_in(vsync_out),
        .drive_on_in(hsync_oe_out), .fire_in(fire), .video_out(video_in), .hsync_out(hsync_in),
        .vsync_out(vsync_in), .csync_out(csync_in), .emb_hsync_out(emb_hsync_in),
        .emb_vsync_out(emb_vsync_in), .trigger_out(trigger_in));
    // activity tallies and the hang limit
    always @(posedge clk_in)
    begin
        h0 <= h0 + exposure_out[0];
        h1 <= h1 + exposure_out[1];
        acqs <= acqs + acq_start_out;
        lns <= lns + line_start_out;
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_total++;
            stop_test;
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic stop_test;
        if (err_total == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // one single word transfer; hready is waited for, never assumed
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] q);
        hsel_in <= 1'b1;
        haddr_in <= a;
        hwrite_in <= wr;
        htrans_in <= `HTRANS_NONSEQ;
        do @(posedge clk_in); while (hreadyout_out !== 1'b1);
        htrans_in <= 2'h0;
        hwdata_in <= wd;
        do @(posedge clk_in); while (hreadyout_out !== 1'b1);
        q = hrdata_out;
        check(hresp_out, 1'b0);
    endtask
    // model skips the kick word and locked setup words
    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        logic [31:0] q;
        bus(1'b1, a, wd, q);
        if (a < 8'h18 && !(regs[1][3] && a > 8'h00 && a < 8'h10))
            regs[a[4:2]] = wd;
    endtask
    task automatic rd(input logic [7:0] a);
        logic [31:0] q;
        bus(1'b0, a, 32'h00000000, q);
        check(q, a < 8'h18 ? regs[a[4:2]] : 32'h00000000);
    endtask
    initial
    begin
        void'($urandom(7));
        repeat (2) @(posedge clk_in);
        rstn_in <= 1'b1;
        @(posedge clk_in);
        for (int i = 0; i < 6; i++) rd(8'(i * 4));
        rd(8'h20);
        // every channel with random gain and palette
        for (int ch = 0; ch < 4; ch++)
        begin
            d = ($urandom & 32'h00000F70) | ch;
            wr(`REG_CTRL, d);
            rd(`REG_CTRL);
            check({gain_out, palette_out}, {d[6:4], d[11:8]});
            @(posedge clk_in) hp = video_in[ch];
            repeat (8) @(posedge clk_in) begin check(video_out, hp); hp = video_in[ch]; end
        end
        // slave mode with each sync scheme
        for (int s = 0; s < 3; s++)
        begin
            wr(`REG_CONFIG, s << 1);
            rd(`REG_CONFIG);
            check(hsync_oe_out, 1'b0);
            check(vsync_oe_out, 1'b0);
            for (int k = 0; k < 60; k++)
            begin
                @(posedge clk_in);
                if (k > 1) check(hsync_out, hp);
                if (k > 1) check(vsync_out, s < 2 ? vp : 1'b0);
                hp = s == 0 ? emb_hsync_in : (s == 1 ? hsync_in : csync_in);
                vp = s == 0 ? emb_vsync_in : vsync_in;
            end
        end
        // two kicks two cycles apart reload timer 0
        d0 = 3 + $urandom % 8;
        d1 = 3 + $urandom % 8;
        wr(`REG_EXP0, d0);
        wr(`REG_EXP1, d1);
        b0 = h0;
        b1 = h1;
        wr(`REG_EXP_KICK, 32'h00000003);
        wr(`REG_EXP_KICK, 32'h00000001);
        repeat (30) @(posedge clk_in);
        check(h0 - b0, d0 + 2);
        check(h1 - b1, d1);
        // master raster, then each trigger mode
        wr(`REG_HTIME, 32'h00000077);
        wr(`REG_VTIME, 32'h00000003);
        wr(`REG_CONFIG, 32'h00000001);
        rd(`REG_CONFIG);
        check(hsync_oe_out, 1'b1);
        check(vsync_oe_out, 1'b1);
        for (int m = 0; m < 3; m++)
        begin
            wr(`REG_CTRL, m << 2);
            a0 = acqs;
            b0 = h0;
            fire <= 1'b1;
            @(posedge clk_in) fire <= 1'b0;
            repeat (600) @(posedge clk_in);
            check(acqs - a0, m != 0);
            check(h0 - b0, m != 0 ? d0 : 0);
        end
        // armed free run: two frames of four lines each in 960 cycles, window opens once arm is in effect
        wr(`REG_CTRL, 32'h00001000);
        repeat (2) @(posedge clk_in);
        a0 = acqs;
        b1 = lns;
        repeat (960) @(posedge clk_in);
        check(acqs - a0, 2);
        check(lns - b1, 8);
        // locked setup refuses writes
        wr(`REG_CONFIG, 32'h00000009);
        wr(`REG_HTIME, 32'h00000005);
        rd(`REG_HTIME);
        rd(`REG_CONFIG);
        stop_test;
    end
endmodule // test_acquisition_sync_trigger_control
bind acq_sync_ctrl acq_sync_monitor acq_sync_monitor_inst (.clk_in, .rstn_in, .hsel_in, .hwrite_in, .video_in,
    .emb_hsync_in, .emb_vsync_in, .hsync_in, .vsync_in, .csync_in, .video_out, .hsync_out, .hsync_oe_out,
    .vsync_out, .vsync_oe_out, .frame_start_out, .acq_start_out, .exposure_out, .gain_out, .palette_out);
`default_nettype wire
